// file: rtl/slm_cfg.svh
// Constants of the converter lock status and mute control block.
// Assumes inclusion by bare name from every file that needs it; the guard makes repeats harmless.
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define SLM_IDX_LOCK 16'hF580
`define SLM_IDX_MUTE 16'hF581
`define SLM_IDX_IRQ_STAT 16'hF582
`define SLM_IDX_IRQ_MASK 16'hF583
`define SLM_ADDR_W 18

// Reset values.
`define SLM_LOCK_RESET 16'h0000
`define SLM_MUTE_RESET 16'h0000
`define SLM_IRQ_RESET 16'h0000

// Field positions and masks of the mute control register.
`define SLM_BIT_RAMP0 8
`define SLM_BIT_RAMP1 9
`define SLM_BIT_AUTO 10
`define SLM_MUTE_WMASK 16'h07FF

// Converter count, group size and ramp length in input samples.
`define SLM_PAIRS 8
`define SLM_GROUP_SIZE 4
`define SLM_RAMP_SAMPLES 2048

`endif

// file: rtl/slm_pkg.sv
// Types shared by the converter lock status and mute control block.
// Assumes the constants header is on the include path.
`include "slm_cfg.svh"

package slm_pkg;

	// One bit per stereo converter.
	typedef logic [`SLM_PAIRS-1:0] slm_pair_vec_t;

	// Whole register state of the top module.
	typedef struct packed {
		logic [15:0] mute;
		slm_pair_vec_t lock;
		logic [15:0] irq_stat;
		logic [15:0] irq_mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} slm_regs_t;

endpackage : slm_pkg

// file: rtl/slm_ramp_if.sv
// Interface between the control logic and one converter's gain ramp.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps

interface slm_ramp_if #(
	parameter int GAIN_W = 12
);
	logic mute_target;
	logic hard_on;
	logic sample_stb;
	logic [GAIN_W-1:0] gain;
	logic muted;

	modport ctrl (output mute_target, output hard_on, output sample_stb, input gain, input muted);
	modport ramp (input mute_target, input hard_on, input sample_stb, output gain, output muted);
endinterface : slm_ramp_if

// file: rtl/slm_gain_ramp.sv
// Linear gain ramp of one stereo converter, one step per input sample.
// Assumes the sample strobe is a one-cycle pulse in the pclk domain.
`timescale 1ns/100ps
`include "slm_cfg.svh"

module slm_gain_ramp #(
	parameter int RAMP_LEN = `SLM_RAMP_SAMPLES,
	parameter int GAIN_W = $clog2(RAMP_LEN) + 1
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control side.
	slm_ramp_if.ramp rif
);
	import slm_pkg::*;

	localparam logic [GAIN_W-1:0] FULL = GAIN_W'(RAMP_LEN);

	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic muted;
	} slm_ramp_st_t;

	slm_ramp_st_t st_r;
	slm_ramp_st_t st_nxt;

	// Unless hard_on forces full gain, the gain moves from where it stands, so a reversal mid-ramp
	// turns round smoothly instead of jumping to either end.
	always_comb begin
		st_nxt = st_r;
		if (rif.hard_on) begin
			st_nxt.gain = FULL;
		end else if (rif.sample_stb) begin
			if (rif.mute_target && st_r.gain != '0) begin
				st_nxt.gain = st_r.gain - 1'b1;
			end else if (!rif.mute_target && st_r.gain != FULL) begin
				st_nxt.gain = st_r.gain + 1'b1;
			end
		end
		st_nxt.muted = (st_nxt.gain == '0);
	end

	// Reset leaves the converter unmuted at full gain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{gain: FULL, muted: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rif.gain = st_r.gain;
	assign rif.muted = st_r.muted;

endmodule : slm_gain_ramp

// file: rtl/slm_top.sv
// Lock status, mute control and gain ramps of eight stereo rate converters.
// Assumes an APB master on pclk and converter datapaths whose lock conditions
// and input sample strobes are synchronous to pclk.
`timescale 1ns/100ps
`include "slm_cfg.svh"

module slm_top #(
	parameter int RAMP_LEN = `SLM_RAMP_SAMPLES,
	parameter int GAIN_W = $clog2(RAMP_LEN) + 1
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SLM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Lock conditions from the converters.
	input wire slm_pkg::slm_pair_vec_t rate_set,
	input wire slm_pkg::slm_pair_vec_t rate_steady,
	input wire slm_pkg::slm_pair_vec_t ratio_done,
	// Audio side.
	input wire slm_pkg::slm_pair_vec_t in_sample_stb,
	output logic [`SLM_PAIRS-1:0][GAIN_W-1:0] pair_gain,
	output slm_pkg::slm_pair_vec_t pair_muted,
	// Interrupt.
	output logic irq
);
	import slm_pkg::*;

	localparam logic [GAIN_W-1:0] FULL = GAIN_W'(RAMP_LEN);

	slm_regs_t r;
	slm_regs_t r_nxt;

	slm_pair_vec_t cond_all;
	slm_pair_vec_t mute_tgt;
	slm_pair_vec_t grp_dis;
	logic setup_ph;
	logic wr_commit;
	logic [15:0] mute_wr;

	// Byte address of a register index.
	function automatic logic addr_hit(input logic [`SLM_ADDR_W-1:0] a, input logic [15:0] idx);
		addr_hit = (a == {idx, 2'b00});
	endfunction : addr_hit

	// Read value of a register; reserved bits read as zero.
	function automatic logic [31:0] read_word(input logic [`SLM_ADDR_W-1:0] a, input slm_regs_t s);
		read_word = 32'h0000_0000;
		if (addr_hit(a, `SLM_IDX_LOCK)) begin
			read_word = {24'h00_0000, s.lock};
		end else if (addr_hit(a, `SLM_IDX_MUTE)) begin
			read_word = {16'h0000, s.mute & `SLM_MUTE_WMASK};
		end else if (addr_hit(a, `SLM_IDX_IRQ_STAT)) begin
			read_word = {16'h0000, s.irq_stat};
		end else if (addr_hit(a, `SLM_IDX_IRQ_MASK)) begin
			read_word = {16'h0000, s.irq_mask};
		end
	endfunction : read_word

	// Whether an address maps onto any register.
	function automatic logic mapped(input logic [`SLM_ADDR_W-1:0] a);
		mapped = addr_hit(a, `SLM_IDX_LOCK) || addr_hit(a, `SLM_IDX_MUTE) ||
			addr_hit(a, `SLM_IDX_IRQ_STAT) || addr_hit(a, `SLM_IDX_IRQ_MASK);
	endfunction : mapped

	// All three lock conditions per converter.
	assign cond_all = rate_set & rate_steady & ratio_done;

	// APB phases; a write lands only at the edge where pready is seen high.
	assign setup_ph = psel && !penable;
	assign wr_commit = psel && penable && r.pready && pwrite;
	assign mute_wr = pwdata[15:0] & `SLM_MUTE_WMASK;

	// Group disable and mute target per converter. The manual bit is ORed in
	// with the lock term, so it holds the mute whatever lock does.
	always_comb begin
		for (int i = 0; i < `SLM_PAIRS; i++) begin
			grp_dis[i] = (i < `SLM_GROUP_SIZE) ? r.mute[`SLM_BIT_RAMP0] : r.mute[`SLM_BIT_RAMP1];
			mute_tgt[i] = !grp_dis[i] && (r.mute[i] || (r.mute[`SLM_BIT_AUTO] && r.lock[i]));
		end
	end

	// Next register state: bus slave, lock capture and interrupt flags.
	always_comb begin
		logic [15:0] lost;
		logic [15:0] clr;
		lost = 16'h0000;
		clr = 16'h0000;
		r_nxt = r;

		// Lock bit is low when locked, high when any condition is missing.
		r_nxt.lock = ~cond_all;

		// Loss of lock sets the low byte, regain sets the high byte.
		lost = {r.lock & ~r_nxt.lock, ~r.lock & r_nxt.lock};

		// Answer one cycle after setup, so every transfer has one wait-free access.
		r_nxt.pready = setup_ph;
		if (setup_ph) begin
			r_nxt.prdata = pwrite ? 32'h0000_0000 : read_word(paddr, r);
			r_nxt.pslverr = !mapped(paddr);
		end else if (!psel) begin
			r_nxt.prdata = 32'h0000_0000;
			r_nxt.pslverr = 1'b0;
		end

		// Writes; the lock register is read only and ignores them.
		if (wr_commit) begin
			if (addr_hit(paddr, `SLM_IDX_MUTE)) begin
				r_nxt.mute = mute_wr;
			end
			if (addr_hit(paddr, `SLM_IDX_IRQ_STAT)) begin
				clr = pwdata[15:0];
			end
			if (addr_hit(paddr, `SLM_IDX_IRQ_MASK)) begin
				r_nxt.irq_mask = pwdata[15:0];
			end
		end

		// A new event in the clearing cycle survives the clear.
		r_nxt.irq_stat = (r.irq_stat & ~clr) | lost;
		r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_mask);
	end

	// State register; everything resets to constants.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{mute: `SLM_MUTE_RESET, lock: slm_pair_vec_t'(`SLM_LOCK_RESET), irq_stat: `SLM_IRQ_RESET,
				irq_mask: `SLM_IRQ_RESET, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
				irq: 1'b0};
		end else begin
			r <= r_nxt;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;

	// One gain ramp per converter, each stepped by its own input samples.
	genvar g;
	generate
		for (g = 0; g < `SLM_PAIRS; g++) begin : g_pair
			slm_ramp_if #(.GAIN_W(GAIN_W)) rif ();
			assign rif.mute_target = mute_tgt[g];
			assign rif.hard_on = grp_dis[g];
			assign rif.sample_stb = in_sample_stb[g];
			assign pair_gain[g] = rif.gain;
			assign pair_muted[g] = rif.muted;
			slm_gain_ramp #(.RAMP_LEN(RAMP_LEN), .GAIN_W(GAIN_W)) u_ramp (
				.pclk(pclk),
				.presetn(presetn),
				.rif(rif)
			);
		end
	endgenerate

	// Helpers for the checks below; converter 0 and 4 stand for their groups.
	logic [GAIN_W-1:0] g0;
	logic [GAIN_W-1:0] g4;
	logic hit_lock_rd;
	assign g0 = pair_gain[0];
	assign g4 = pair_gain[4];
	assign hit_lock_rd = setup_ph && !pwrite && addr_hit(paddr, `SLM_IDX_LOCK);

	property p_locked_all;
		@(posedge pclk) disable iff (!presetn)
		(cond_all == 8'hFF) |=> (r.lock == 8'h00);
	endproperty
	a_locked_all: assert property (p_locked_all) else $error("Lock bits not all low with all conditions met.");

	// The sampled reset keeps the release edge, where the state is still held, out of this check.
	property p_lock_polarity;
		@(posedge pclk) disable iff (!presetn)
		presetn |=> (r.lock == ~$past(cond_all));
	endproperty
	a_lock_polarity: assert property (p_lock_polarity) else $error("Lock bit polarity or timing wrong.");

	property p_lock_read;
		@(posedge pclk) disable iff (!presetn)
		hit_lock_rd |=> (prdata[31:8] == 24'h00_0000) && (prdata[7:0] == $past(r.lock)) && pready && !pslverr;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("Lock register read returned wrong data.");

	property p_mute_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_commit && addr_hit(paddr, `SLM_IDX_MUTE)) |=> (r.mute == $past(mute_wr));
	endproperty
	a_mute_write: assert property (p_mute_write) else $error("Mute register write not stored.");

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		r.mute[15:11] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved mute bits became set.");

	property p_step_only_on_sample;
		@(posedge pclk) disable iff (!presetn)
		(!in_sample_stb[0] && !r.mute[`SLM_BIT_RAMP0]) |=> (g0 == $past(g0));
	endproperty
	a_step_only_on_sample: assert property (p_step_only_on_sample) else $error("Gain moved without a sample.");

	property p_gain_bounded;
		@(posedge pclk) disable iff (!presetn)
		(g0 <= FULL) && (g4 <= FULL);
	endproperty
	a_gain_bounded: assert property (p_gain_bounded) else $error("Gain exceeded full scale.");

	property p_auto_mute_down;
		@(posedge pclk) disable iff (!presetn)
		(r.mute[`SLM_BIT_AUTO] && r.lock[0] && !r.mute[`SLM_BIT_RAMP0] && in_sample_stb[0] && g0 != '0)
		|=> (g0 == $past(g0) - 1'b1);
	endproperty
	a_auto_mute_down: assert property (p_auto_mute_down) else $error("Automatic mute did not ramp down.");

	property p_relock_up;
		@(posedge pclk) disable iff (!presetn)
		(r.mute[`SLM_BIT_AUTO] && !r.lock[0] && !r.mute[0] && !r.mute[`SLM_BIT_RAMP0] && in_sample_stb[0]
			&& g0 != FULL) |=> (g0 == $past(g0) + 1'b1);
	endproperty
	a_relock_up: assert property (p_relock_up) else $error("Relock did not ramp gain up.");

	property p_manual_wins;
		@(posedge pclk) disable iff (!presetn)
		(r.mute[0] && !r.lock[0] && !r.mute[`SLM_BIT_RAMP0] && in_sample_stb[0] && g0 != '0)
		|=> (g0 == $past(g0) - 1'b1);
	endproperty
	a_manual_wins: assert property (p_manual_wins) else $error("Manual mute did not hold while locked.");

	property p_group_split;
		@(posedge pclk) disable iff (!presetn)
		(r.mute[`SLM_BIT_RAMP0] && !r.mute[`SLM_BIT_RAMP1] && r.mute[4] && in_sample_stb[4] && g4 != '0)
		|=> (g0 == FULL) && (g4 == $past(g4) - 1'b1);
	endproperty
	a_group_split: assert property (p_group_split) else $error("Group disable crossed into other group.");

	property p_disable_full;
		@(posedge pclk) disable iff (!presetn)
		r.mute[`SLM_BIT_RAMP1] [*2] |-> (g4 == FULL) && !pair_muted[7];
	endproperty
	a_disable_full: assert property (p_disable_full) else $error("Disabled group not fully active.");

	property p_ramp_enable_bits;
		@(posedge pclk) disable iff (!presetn)
		(grp_dis[3] == r.mute[`SLM_BIT_RAMP0]) && (grp_dis[7] == r.mute[`SLM_BIT_RAMP1]);
	endproperty
	a_ramp_enable_bits: assert property (p_ramp_enable_bits) else $error("Ramp disable bit mapped wrongly.");

	// Bus, interrupt, muted flag and group one disable checks; the event flags are watched on converter 0 only.
	property p_ready_after_setup;
		@(posedge pclk) disable iff (!presetn)
		setup_ph |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("No answer after a setup cycle.");

	property p_idle_zero;
		@(posedge pclk) disable iff (!presetn)
		!psel |=> (prdata == 32'h0000_0000) && !pready && !pslverr;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("Bus outputs not quiet while idle.");

	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !mapped(paddr)) |=> pready && pslverr && (prdata == 32'h0000_0000);
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped address not refused.");

	property p_lock_wr_ignored;
		@(posedge pclk) disable iff (!presetn)
		(wr_commit && addr_hit(paddr, `SLM_IDX_LOCK)) |=> $stable(r.mute) && $stable(r.irq_mask);
	endproperty
	a_lock_wr_ignored: assert property (p_lock_wr_ignored) else $error("Lock register write changed state.");

	property p_read_mute;
		@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && addr_hit(paddr, `SLM_IDX_MUTE))
		|=> (prdata == {16'h0000, $past(r.mute)}) && pready && !pslverr;
	endproperty
	a_read_mute: assert property (p_read_mute) else $error("Mute register read returned wrong data.");

	property p_lost_sets;
		@(posedge pclk) disable iff (!presetn)
		(presetn && !r.lock[0] && !cond_all[0]) |=> r.irq_stat[0];
	endproperty
	a_lost_sets: assert property (p_lost_sets) else $error("Loss of lock did not set its flag.");

	property p_regain_sets;
		@(posedge pclk) disable iff (!presetn)
		(r.lock[0] && cond_all[0]) |=> r.irq_stat[8];
	endproperty
	a_regain_sets: assert property (p_regain_sets) else $error("Regained lock did not set its flag.");

	property p_stat_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_commit && addr_hit(paddr, `SLM_IDX_IRQ_STAT) && pwdata[0] && (r.lock[0] || cond_all[0]))
		|=> !r.irq_stat[0];
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("Writing one did not clear the flag.");

	property p_mask_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_commit && addr_hit(paddr, `SLM_IDX_IRQ_MASK)) |=> (r.irq_mask == $past(pwdata[15:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Mask register write not stored.");

	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		irq == |(r.irq_stat & r.irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt level disagrees with flags.");

	property p_muted_flag;
		@(posedge pclk) disable iff (!presetn)
		(pair_muted[0] == (g0 == '0)) && (pair_muted[4] == (g4 == '0));
	endproperty
	a_muted_flag: assert property (p_muted_flag) else $error("Muted flag disagrees with gain.");

	property p_ramp1_group;
		@(posedge pclk) disable iff (!presetn)
		(r.mute[`SLM_BIT_RAMP1] && !r.mute[`SLM_BIT_RAMP0] && r.mute[0] && in_sample_stb[0] && g0 != '0)
		|=> (g4 == FULL) && (g0 == $past(g0) - 1'b1);
	endproperty
	a_ramp1_group: assert property (p_ramp1_group) else $error("Group one disable crossed into group zero.");

endmodule : slm_top

// file: test/slm_conv_model.sv
// Stand-in for the converter datapaths: lock conditions and sample strobes.
// Assumes the bench names the converters that lose lock; runs on pclk.
`timescale 1ns/100ps

module slm_conv_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Converters told to lose lock.
	input wire slm_pkg::slm_pair_vec_t lose,
	// Lock conditions and input sample strobes.
	output slm_pkg::slm_pair_vec_t rate_set,
	output slm_pkg::slm_pair_vec_t rate_steady,
	output slm_pkg::slm_pair_vec_t ratio_done,
	output slm_pkg::slm_pair_vec_t in_sample_stb
);
	import slm_pkg::*;

	// A losing converter drops one condition picked at random, so every cause of unlock is seen.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_set <= '0;
			rate_steady <= '0;
			ratio_done <= '0;
			in_sample_stb <= '0;
		end else begin
			for (int i = 0; i < 8; i++) begin
				int c;
				c = lose[i] ? $urandom_range(2) : 3;
				rate_set[i] <= (c != 0);
				rate_steady[i] <= (c != 1);
				ratio_done[i] <= (c != 2);
				in_sample_stb[i] <= 1'($urandom_range(1));
			end
		end
	end
endmodule : slm_conv_model

// file: test/tb_top.sv
// Self-checking bench of the lock status and mute control block.
// Assumes the design files and the converter stand-in are compiled first.
`timescale 1ns/100ps
`include "slm_cfg.svh"

module tb_top;
	import slm_pkg::*;

	localparam int RL = 16;
	localparam int GW = $clog2(RL) + 1;
	localparam logic [17:0] A_LOCK = {`SLM_IDX_LOCK, 2'b00};
	localparam logic [17:0] A_MUTE = {`SLM_IDX_MUTE, 2'b00};
	localparam logic [17:0] A_STAT = {`SLM_IDX_IRQ_STAT, 2'b00};
	localparam logic [17:0] A_MASK = {`SLM_IDX_IRQ_MASK, 2'b00};
	localparam logic [GW-1:0] UNITY = GW'(RL);
	localparam logic [15:0] MODES [8] = '{16'h0001, 16'h0000, 16'h0001, 16'h0400, 16'h0510, 16'h04F0, 16'h02F0, 16'h0000};
	localparam logic [7:0] LOSES [8] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h00, 8'hF0, 8'h00};
	localparam int WAITS [8] = '{40, 8, 40, 40, 20, 40, 20, 40};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, err;
	slm_pair_vec_t rate_set, rate_steady, ratio_done, in_sample_stb, pair_muted, lock_m;
	slm_pair_vec_t lose = '0;
	logic [7:0][GW-1:0] pair_gain, gain_m;
	logic [15:0] mute_m;
	int n_fail = 0;
	int num_checks = 0;

	always #2 pclk = ~pclk;

	slm_top #(.RAMP_LEN(RL), .GAIN_W(GW)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rate_set(rate_set), .rate_steady(rate_steady),
		.ratio_done(ratio_done), .in_sample_stb(in_sample_stb), .pair_gain(pair_gain),
		.pair_muted(pair_muted), .irq(irq));
	slm_conv_model u_conv (.pclk(pclk), .presetn(presetn), .lose(lose), .rate_set(rate_set),
		.rate_steady(rate_steady), .ratio_done(ratio_done), .in_sample_stb(in_sample_stb));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			test_done();
		end
	endtask : apb

	// Gain one edge on: a disabled group sits at unity, otherwise one step per strobe.
	function automatic logic [GW-1:0] next_gain(input int i);
		logic tgt;
		tgt = mute_m[i] | (mute_m[10] & lock_m[i]);
		if (mute_m[8 + i / 4]) return UNITY;
		if (!in_sample_stb[i]) return gain_m[i];
		if (tgt && gain_m[i] != '0) return gain_m[i] - 1'b1;
		if (!tgt && gain_m[i] != UNITY) return gain_m[i] + 1'b1;
		return gain_m[i];
	endfunction : next_gain

	// Reference of the registers and gains, stepped on the same edges as the design.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_m <= '0;
			lock_m <= '0;
			gain_m <= {8{UNITY}};
		end else begin
			lock_m <= ~(rate_set & rate_steady & ratio_done);
			if (psel && penable && pready && pwrite && paddr == A_MUTE) mute_m <= pwdata[15:0] & 16'h07FF;
			for (int i = 0; i < 8; i++) gain_m[i] <= next_gain(i);
		end
	end

	// Every cycle is compared, so both step size and step timing are held to the reference.
	always @(negedge pclk) begin
		if (presetn) begin
			for (int i = 0; i < 8; i++) begin
				chk(32'(pair_gain[i]), 32'(gain_m[i]));
				chk(32'(pair_muted[i]), 32'(gain_m[i] == '0));
			end
		end
	end

	initial begin
		void'($urandom(32'h5B303AD4));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, A_MUTE, 0);
		chk(rd, 32'h0);
		apb(1, A_MUTE, 32'hFFFF_F800);
		apb(0, A_MUTE, 0);
		chk(rd, 32'h0);
		apb(1, A_LOCK, 32'hFFFF);
		apb(0, A_LOCK, 0);
		chk(rd, 32'h0);
		apb(0, A_MASK + 18'h4, 0);
		chk({rd[30:0], err}, 32'h1);
		// Lock loss on random converters, through a random failing condition.
		for (int n = 0; n < 12; n++) begin
			lose <= 8'($urandom);
			repeat (3) @(posedge pclk);
			apb(0, A_LOCK, 0);
			chk(rd, {24'h0, lose});
		end
		// Interrupt: masked event stays quiet, enabled one raises, clear drops it.
		lose <= '0;
		repeat (4) @(posedge pclk);
		apb(1, A_MASK, 32'h1);
		apb(1, A_STAT, 32'hFFFF);
		lose <= 8'h02;
		repeat (4) @(posedge pclk);
		chk(irq, 0);
		apb(0, A_STAT, 0);
		chk(rd, 32'h2);
		lose <= 8'h03;
		repeat (4) @(posedge pclk);
		chk(irq, 1);
		apb(1, A_STAT, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		// Directed mute modes, then random ones; the reference judges the gains.
		foreach (MODES[m]) begin
			lose <= LOSES[m];
			apb(1, A_MUTE, {16'h0, MODES[m]});
			repeat (WAITS[m]) @(posedge pclk);
		end
		for (int n = 0; n < 30; n++) begin
			lose <= 8'($urandom);
			apb(1, A_MUTE, 32'($urandom));
			repeat ($urandom_range(30, 1)) @(posedge pclk);
		end
		apb(0, A_MUTE, 0);
		chk(rd, {16'h0, mute_m});
		test_done();
	end
endmodule : tb_top
